// *** inc/sersh_pkg.sv ***
// Constants and types for the SPI EEPROM command, status and array logic
package sersh_pkg;
    localparam logic [7:0] OP_LATCH_SET = 8'h06;
    localparam logic [7:0] OP_LATCH_CLR = 8'h04;
    localparam logic [7:0] OP_STATUS_READ = 8'h05;
    localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
    localparam logic [7:0] OP_ARRAY_READ = 8'h03;
    localparam logic [7:0] OP_ARRAY_WRITE = 8'h02;
    localparam int SB_READY = 0;
    localparam int SB_LATCH = 1;
    localparam int SB_GUARD_LO = 2;
    localparam int SB_GUARD_HI = 3;
    localparam int SB_LOCK = 4;
    localparam int SB_ZERO = 5;
    localparam int SB_IDSEL = 6;
    localparam int SB_GATE = 7;
    localparam logic [7:0] STATUS_WR_MASK = 8'hDC;
    localparam logic [7:0] BUSY_STATUS = 8'hFF;
    localparam logic [7:0] ERASED_BYTE = 8'hFF;
    localparam logic [1:0] GUARD_QUARTER = 2'h1;
    localparam logic [1:0] GUARD_HALF = 2'h2;
    localparam logic [1:0] GUARD_FULL = 2'h3;
    localparam int MEM_DEPTH = 16384;
    localparam int PAGE_BYTES = 64;
    localparam logic [6:0] COPY_DONE = 7'h40;
    localparam logic [4:0] CMD_LAST = 5'h7;
    localparam logic [4:0] ADDR_LAST = 5'hF;
    localparam logic [2:0] BYTE_LAST = 3'h7;
    localparam int CLK_PERIOD_NS = 10;
    localparam int WRITE_TIME_NS = 5000000;
    localparam int WRITE_CYCLES = WRITE_TIME_NS / CLK_PERIOD_NS;
    typedef enum logic [8:0] {
        ST_IDLE = 9'h001,
        ST_CMD = 9'h002,
        ST_ADDR = 9'h004,
        ST_RDAT = 9'h008,
        ST_WDAT = 9'h010,
        ST_SRD = 9'h020,
        ST_SWR = 9'h040,
        ST_ARM = 9'h080,
        ST_IGN = 9'h100
    } sersh_state_t;
endpackage

// *** hw/sersh_core.sv ***
// SPI EEPROM serial command, status, hold and array logic
`timescale 1ns/1ns
// Behaviour
// - status write changes only bits 2,3,4,6,7
// - protect pin low with gate refuses status write
// - protect fall during selection aborts status write
// - started status write cycle ignores protect pin
// - gate bit zero makes protect pin ignored
// - read opcode, 16-bit address, then data out
// - read address increments, wraps, ends on deselect
// - id page read uses six address bits
// - status read accepted anytime, status shifted out
// - status read while busy returns all ones
// - hold tristates output and freezes transfer
// - reset gives standby with write latch clear
// - completed write clears the write latch
// - exact clock count then deselect starts write
// - array commands ignored during write cycle
// - unknown opcode ignored, output stays off
// - array reads all ones before any write
// - array read opcode is 03 hex
// - ready bit high while write cycle runs
// - id page select clears after each access
// - array uses fourteen low address bits
module sersh_core #(
    parameter int WRITE_CYCLES = sersh_pkg::WRITE_CYCLES
) (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic cs_n,
    input wire logic sck,
    input wire logic si,
    input wire logic hold_n,
    input wire logic wp_n,
    output logic so,
    output logic so_oe,
    output logic write_busy
);
    import sersh_pkg::*;

    logic [2:0] sck_r, cs_r;
    logic [1:0] si_r, hold_r, wp_r;
    logic sel, hold_ok, rise, fall, cs_fall, cs_rise;
    sersh_state_t st_r, st_nxt;
    logic [4:0] bits_r, bits_nxt;
    logic [7:0] sh_r, sh_nxt, op_r, op_nxt, out_r, out_nxt, swv_r, swv_nxt;
    logic [15:0] addr_r, addr_nxt, rd_a, addr_inc;
    logic [2:0] ocnt_r, ocnt_nxt;
    logic so_r, so_nxt, drv_r, drv_nxt, oe_r, oe_nxt, abort_r, abort_nxt;
    logic wlat_r, wlat_nxt, gate_r, gate_nxt, idsel_r, idsel_nxt, lock_r, lock_nxt;
    logic [1:0] guard_r, guard_nxt;
    logic busy_r, busy_nxt, wid_r, wid_nxt;
    logic [6:0] copy_r, copy_nxt;
    logic [19:0] tmr_r, tmr_nxt;
    logic [7:0] wpage_r, wpage_nxt;
    logic [63:0] bvld_r, bvld_nxt;
    logic [7:0] buf_r [PAGE_BYTES];
    logic [7:0] mem_r [MEM_DEPTH];
    logic [7:0] idp_r [PAGE_BYTES];
    logic [7:0] din, stat_w, stat_rd, rd_d, sw_new, buf_d, mem_wd;
    logic buf_we, mem_we, swr_go, wr_go, wprot, tmr_end, swr_cmd;
    logic [5:0] buf_idx;
    logic [13:0] mem_wa;

    // Pin synchronisers; only the second and third stages are read
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            sck_r <= 3'h0;
            cs_r <= 3'h7;
            si_r <= 2'h0;
            hold_r <= 2'h3;
            wp_r <= 2'h3;
        end else begin
            sck_r <= {sck_r[1:0], sck};
            cs_r <= {cs_r[1:0], cs_n};
            si_r <= {si_r[0], si};
            hold_r <= {hold_r[0], hold_n};
            wp_r <= {wp_r[0], wp_n};
        end
    end

    assign sel = !cs_r[1];
    // clock edges are dropped while held
    assign hold_ok = hold_r[1];
    // rising edges sample, falling edges drive
    assign rise = sel && hold_ok && sck_r[1] && !sck_r[2];
    assign fall = sel && hold_ok && !sck_r[1] && sck_r[2];
    assign cs_fall = !cs_r[1] && cs_r[2];
    assign cs_rise = cs_r[1] && !cs_r[2];
    assign din = {sh_r[6:0], si_r[1]};
    // ready bit mirrors the write cycle
    assign stat_w = {gate_r, idsel_r, 1'b0, lock_r, guard_r, wlat_r, busy_r};
    // busy status reads as all ones
    assign stat_rd = busy_r ? BUSY_STATUS : stat_w;
    // id page wraps in six bits, array in fourteen
    assign addr_inc = idsel_r ? {addr_r[15:6], addr_r[5:0] + 6'h1}
                              : {addr_r[15:14], addr_r[13:0] + 14'h1};
    assign rd_a = (st_r == ST_ADDR) ? {addr_r[14:0], si_r[1]} : addr_inc;
    // id page uses six address bits
    // array ignores the two upper bits
    assign rd_d = idsel_r ? idp_r[rd_a[5:0]] : mem_r[rd_a[13:0]];
    assign tmr_end = busy_r && (tmr_r == 20'(WRITE_CYCLES - 1));
    assign swr_cmd = cs_rise && (st_r == ST_ARM) && (op_r == OP_STATUS_WRITE);

    always_comb begin
        sw_new = (stat_w & ~STATUS_WR_MASK) | (swv_r & STATUS_WR_MASK);
        if (swv_r[SB_IDSEL] && swv_r[SB_LOCK]) begin
            sw_new[SB_IDSEL] = idsel_r;
            sw_new[SB_LOCK] = lock_r;
        end
        if (idsel_r) begin
            wprot = (guard_r == GUARD_FULL) || lock_r;
        end else begin
            wprot = (guard_r == GUARD_FULL) || (guard_r == GUARD_HALF && addr_r[13])
                || (guard_r == GUARD_QUARTER && addr_r[13:12] == 2'h3);
        end
        st_nxt = st_r;
        bits_nxt = bits_r;
        sh_nxt = sh_r;
        op_nxt = op_r;
        out_nxt = out_r;
        swv_nxt = swv_r;
        addr_nxt = addr_r;
        ocnt_nxt = ocnt_r;
        so_nxt = so_r;
        drv_nxt = drv_r;
        abort_nxt = abort_r;
        wlat_nxt = wlat_r;
        gate_nxt = gate_r;
        idsel_nxt = idsel_r;
        lock_nxt = lock_r;
        guard_nxt = guard_r;
        busy_nxt = busy_r;
        wid_nxt = wid_r;
        copy_nxt = copy_r;
        tmr_nxt = tmr_r;
        wpage_nxt = wpage_r;
        bvld_nxt = bvld_r;
        buf_we = 1'b0;
        buf_idx = addr_r[5:0];
        buf_d = din;
        swr_go = 1'b0;
        wr_go = 1'b0;
        // running write cycle ignores the protect pin
        if (busy_r) begin
            tmr_nxt = tmr_r + 20'h1;
            if (copy_r != COPY_DONE) begin
                copy_nxt = copy_r + 7'h1;
            end
            if (tmr_end) begin
                busy_nxt = 1'b0;
                wlat_nxt = 1'b0;
            end
        end
        if (cs_fall) begin
            st_nxt = ST_CMD;
            bits_nxt = 5'h0;
            abort_nxt = 1'b0;
            drv_nxt = 1'b0;
        end else if (cs_rise) begin
            st_nxt = ST_IDLE;
            drv_nxt = 1'b0;
            if (st_r == ST_ARM) begin
                case (op_r)
                    OP_LATCH_SET: begin
                        wlat_nxt = 1'b1;
                    end
                    OP_LATCH_CLR: begin
                        wlat_nxt = 1'b0;
                    end
                    default: begin
                        // an earlier protect fall aborts it
                        // gate low ignores the protect pin
                        swr_go = !abort_r && !(gate_r && !wp_r[1]);
                    end
                endcase
            end
            // only a whole byte count commits the write
            wr_go = (st_r == ST_WDAT) && (bits_r == 5'h0) && (bvld_r != 64'h0) && !wprot;
            // only writable bits take the new value
            if (swr_go) begin
                gate_nxt = sw_new[SB_GATE];
                idsel_nxt = sw_new[SB_IDSEL];
                lock_nxt = lock_r | sw_new[SB_LOCK];
                guard_nxt = sw_new[SB_GUARD_HI:SB_GUARD_LO];
                busy_nxt = 1'b1;
                tmr_nxt = 20'h0;
                copy_nxt = COPY_DONE;
            end
            if (wr_go) begin
                wid_nxt = idsel_r;
                wpage_nxt = addr_r[13:6];
                busy_nxt = 1'b1;
                tmr_nxt = 20'h0;
                copy_nxt = 7'h0;
            end
            // id page select clears after an access
            if (st_r == ST_RDAT || wr_go) begin
                idsel_nxt = 1'b0;
            end
        end else if (rise) begin
            case (st_r)
                ST_CMD: begin
                    sh_nxt = din;
                    bits_nxt = bits_r + 5'h1;
                    if (bits_r == CMD_LAST) begin
                        op_nxt = din;
                        bits_nxt = 5'h0;
                        st_nxt = ST_IGN;
                        // status read is taken even while busy
                        if (din == OP_STATUS_READ) begin
                            st_nxt = ST_SRD;
                            out_nxt = stat_rd;
                            ocnt_nxt = 3'h0;
                        // other commands are dropped while busy
                        end else if (!busy_r) begin
                            case (din)
                                OP_LATCH_SET, OP_LATCH_CLR: begin
                                    st_nxt = ST_ARM;
                                end
                                OP_STATUS_WRITE: begin
                                    st_nxt = wlat_r ? ST_SWR : ST_IGN;
                                end
                                OP_ARRAY_READ: begin
                                    st_nxt = ST_ADDR;
                                end
                                OP_ARRAY_WRITE: begin
                                    st_nxt = wlat_r ? ST_ADDR : ST_IGN;
                                end
                                default: begin
                                    st_nxt = ST_IGN;
                                end
                            endcase
                        end
                    end
                end
                ST_ADDR: begin
                    addr_nxt = {addr_r[14:0], si_r[1]};
                    bits_nxt = bits_r + 5'h1;
                    // data follows the last address bit
                    if (bits_r == ADDR_LAST) begin
                        bits_nxt = 5'h0;
                        ocnt_nxt = 3'h0;
                        out_nxt = rd_d;
                        bvld_nxt = 64'h0;
                        st_nxt = (op_r == OP_ARRAY_READ) ? ST_RDAT : ST_WDAT;
                    end
                end
                ST_WDAT: begin
                    sh_nxt = din;
                    bits_nxt = bits_r + 5'h1;
                    if (bits_r == CMD_LAST) begin
                        bits_nxt = 5'h0;
                        buf_we = 1'b1;
                        bvld_nxt[addr_r[5:0]] = 1'b1;
                        addr_nxt = {addr_r[15:6], addr_r[5:0] + 6'h1};
                    end
                end
                ST_SWR: begin
                    sh_nxt = din;
                    bits_nxt = bits_r + 5'h1;
                    if (bits_r == CMD_LAST) begin
                        swv_nxt = din;
                        st_nxt = ST_ARM;
                    end
                end
                ST_ARM: begin
                    st_nxt = ST_IGN;
                end
                default: begin
                    st_nxt = st_r;
                end
            endcase
        end else if (fall && (st_r == ST_RDAT || st_r == ST_SRD)) begin
            drv_nxt = 1'b1;
            so_nxt = out_r[7];
            out_nxt = {out_r[6:0], 1'b0};
            ocnt_nxt = ocnt_r + 3'h1;
            // next byte loads as the last bit leaves
            if (ocnt_r == BYTE_LAST) begin
                if (st_r == ST_RDAT) begin
                    addr_nxt = addr_inc;
                    out_nxt = rd_d;
                end else begin
                    out_nxt = stat_rd;
                end
            end
        end
        // protect fall during selection marks abort
        if ((st_r == ST_SWR || st_r == ST_ARM) && op_r == OP_STATUS_WRITE
            && gate_r && !wp_r[1]) begin
            abort_nxt = 1'b1;
        end
        oe_nxt = sel && hold_ok && drv_nxt;
    end

    // standby with latch clear after reset
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            st_r <= ST_IDLE;
            bits_r <= 5'h0;
            sh_r <= 8'h00;
            op_r <= 8'h00;
            out_r <= 8'h00;
            swv_r <= 8'h00;
            addr_r <= 16'h0000;
            ocnt_r <= 3'h0;
            so_r <= 1'b0;
            drv_r <= 1'b0;
            oe_r <= 1'b0;
            abort_r <= 1'b0;
            wlat_r <= 1'b0;
            gate_r <= 1'b0;
            idsel_r <= 1'b0;
            lock_r <= 1'b0;
            guard_r <= 2'h0;
            busy_r <= 1'b0;
            wid_r <= 1'b0;
            copy_r <= COPY_DONE;
            tmr_r <= 20'h0;
            wpage_r <= 8'h00;
            bvld_r <= 64'h0;
        end else begin
            st_r <= st_nxt;
            bits_r <= bits_nxt;
            sh_r <= sh_nxt;
            op_r <= op_nxt;
            out_r <= out_nxt;
            swv_r <= swv_nxt;
            addr_r <= addr_nxt;
            ocnt_r <= ocnt_nxt;
            so_r <= so_nxt;
            drv_r <= drv_nxt;
            oe_r <= oe_nxt;
            abort_r <= abort_nxt;
            wlat_r <= wlat_nxt;
            gate_r <= gate_nxt;
            idsel_r <= idsel_nxt;
            lock_r <= lock_nxt;
            guard_r <= guard_nxt;
            busy_r <= busy_nxt;
            wid_r <= wid_nxt;
            copy_r <= copy_nxt;
            tmr_r <= tmr_nxt;
            wpage_r <= wpage_nxt;
            bvld_r <= bvld_nxt;
        end
    end

    // Page buffer is copied into the array one byte per cycle
    always_comb begin
        mem_wa = {wpage_r, copy_r[5:0]};
        mem_wd = buf_r[copy_r[5:0]];
        mem_we = busy_r && (copy_r != COPY_DONE) && bvld_r[copy_r[5:0]];
    end

    always_ff @(posedge core_clk) begin
        if (buf_we) begin
            buf_r[buf_idx] <= buf_d;
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < MEM_DEPTH; i++) begin
                mem_r[i] <= ERASED_BYTE;
            end
            for (int i = 0; i < PAGE_BYTES; i++) begin
                idp_r[i] <= ERASED_BYTE;
            end
        end else if (mem_we) begin
            if (wid_r) begin
                idp_r[mem_wa[5:0]] <= mem_wd;
            end else begin
                mem_r[mem_wa] <= mem_wd;
            end
        end
    end

    assign so = so_r;
    assign so_oe = oe_r;
    assign write_busy = busy_r;

    default clocking dc @(posedge core_clk); endclocking
    default disable iff (!reset_n);

    swr_mask_a: assert property (
        swr_go |=> stat_w[SB_ZERO] == 1'b0 && wlat_r == $past(wlat_r)
            && gate_r == $past(swv_r[SB_GATE]) && guard_r == $past(swv_r[3:2]))
        else $error("status write touched a fixed bit");
    wp_refuse_a: assert property (
        swr_cmd && gate_r && !wp_r[1] |=> !busy_r && $stable(guard_r))
        else $error("protected status write was taken");
    wp_abort_a: assert property (
        swr_cmd && abort_r |=> !busy_r) else $error("aborted status write ran");
    wp_late_a: assert property (
        busy_r && !tmr_end && !wp_r[1] |=> busy_r) else $error("protect pin cut write");
    gate_off_a: assert property (
        swr_cmd && !gate_r |=> busy_r) else $error("ungated status write refused");
    read_start_a: assert property (
        rise && st_r == ST_ADDR && bits_r == ADDR_LAST && op_r == OP_ARRAY_READ
            |=> st_r == ST_RDAT && out_r == $past(rd_d))
        else $error("read data not loaded after address");
    addr_wrap_a: assert property (
        fall && st_r == ST_RDAT && ocnt_r == BYTE_LAST && !idsel_r
            && addr_r[13:0] == 14'h3FFF |=> addr_r[13:0] == 14'h0)
        else $error("read address did not wrap");
    status_read_a: assert property (
        rise && st_r == ST_CMD && bits_r == CMD_LAST && din == OP_STATUS_READ
            |=> st_r == ST_SRD && out_r == ($past(busy_r) ? BUSY_STATUS : $past(stat_w)))
        else $error("status read not answered");
    hold_off_a: assert property (
        !hold_r[1] |=> !so_oe) else $error("output driven during hold");
    latch_clear_a: assert property (
        tmr_end |=> !wlat_r && !busy_r) else $error("latch kept after write");
    busy_ignore_a: assert property (
        busy_r && rise && st_r == ST_CMD && bits_r == CMD_LAST && din != OP_STATUS_READ
            |=> st_r == ST_IGN) else $error("command taken while busy");
    invalid_off_a: assert property (
        st_r == ST_IGN |=> !so_oe) else $error("output driven after bad opcode");

    read_seen_c: cover property (st_r == ST_RDAT && fall && ocnt_r == BYTE_LAST);
    busy_poll_c: cover property (busy_r && st_r == ST_SRD && fall);
    swr_done_c: cover property (swr_go ##[1:1000] tmr_end);
    hold_seen_c: cover property (drv_r && !hold_r[1]);
endmodule

// *** tb/sersh_host.sv ***
// Host model of the serial link: select, clock, data, hold and protect pins
`timescale 1ns/1ns
module sersh_host (
    input wire logic core_clk,
    output logic cs_n,
    output logic sck,
    output logic si,
    output logic hold_n,
    output logic wp_n,
    input wire logic so,
    input wire logic so_oe
);
    logic idle_hi;
    initial begin
        idle_hi = 1'b0;
        cs_n = 1'b1;
        sck = 1'b0;
        si = 1'b0;
        hold_n = 1'b1;
        wp_n = 1'b1;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #2;
    endtask
    // clock idle level, changed only while deselected
    task automatic set_mode(input logic hi);
        idle_hi = hi;
        sck = hi;
        tick(2);
    endtask
    task automatic sel();
        cs_n = 1'b0;
        tick(8);
    endtask
    task automatic desel();
        tick(8);
        cs_n = 1'b1;
        si = ~si;
        tick(6);
    endtask
    // MSB first, hold moves only with clock low
    task automatic xfer(input logic [7:0] tx, input int hold_at, output logic [7:0] rx,
                        output logic oe_any, output logic oe_hold);
        oe_any = 1'b0;
        oe_hold = 1'b0;
        for (int i = 7; i >= 0; i--) begin
            if (idle_hi) begin
                sck = 1'b0;
            end
            si = tx[i];
            if (i == hold_at) begin
                tick(4);
                hold_n = 1'b0;
                tick(8);
                oe_hold = so_oe;
                // clock and data wiggle while held
                si = ~si;
                sck = 1'b1;
                tick(4);
                sck = 1'b0;
                tick(4);
                si = tx[i];
                hold_n = 1'b1;
                tick(4);
            end
            tick(8);
            sck = 1'b1;
            rx[i] = so;
            oe_any = oe_any | so_oe;
            tick(8);
            if (!idle_hi) begin
                sck = 1'b0;
            end
        end
    endtask
endmodule

// *** tb/spi_eeprom_read_status_hold_test.sv ***
// Self-checking bench for the serial EEPROM command logic
`timescale 1ns/1ns
module spi_eeprom_read_status_hold_test;
    import sersh_pkg::*;
    localparam int WCYC = 2000;
    logic core_clk = 1'b0;
    logic reset_n = 1'b0;
    logic cs_n, sck, si, hold_n, wp_n, so, so_oe, write_busy;
    int fail_count = 0;
    int check_count = 0;
    int seed = 55594;
    logic [7:0] rx, st, v, d0, d1, op;
    logic oe_any, oe_hold, oe_acc;
    logic [7:0] mem_exp [int];
    always #5 core_clk = ~core_clk;
    sersh_core #(.WRITE_CYCLES(WCYC)) DUT (.core_clk(core_clk), .reset_n(reset_n),
        .cs_n(cs_n), .sck(sck), .si(si), .hold_n(hold_n), .wp_n(wp_n), .so(so),
        .so_oe(so_oe), .write_busy(write_busy));
    sersh_host host (.core_clk(core_clk), .cs_n(cs_n), .sck(sck), .si(si),
        .hold_n(hold_n), .wp_n(wp_n), .so(so), .so_oe(so_oe));
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask
    function automatic logic [7:0] exp_byte(input logic [15:0] a, input logic idp);
        if (idp || !mem_exp.exists(int'(a[13:0]))) return 8'hFF;
        return mem_exp[int'(a[13:0])];
    endfunction
    task automatic xb(input logic [7:0] tx, input int hold_at = 8);
        host.xfer(tx, hold_at, rx, oe_any, oe_hold);
    endtask
    task automatic rd_status();
        host.sel();
        xb(OP_STATUS_READ);
        xb(8'h00);
        st = rx;
        host.desel();
    endtask
    task automatic wait_ready();
        for (int i = 0; i < 40; i++) begin
            rd_status();
            if (st[0] === 1'b0) return;
        end
        fail_count++;
        report_and_stop();
    endtask
    task automatic latch_set();
        host.sel();
        xb(OP_LATCH_SET);
        host.desel();
    endtask
    task automatic wr_status(input logic [7:0] val, input logic wp_mid);
        latch_set();
        host.sel();
        xb(OP_STATUS_WRITE);
        xb(val);
        if (wp_mid) begin
            host.wp_n = 1'b0;
            host.tick(4);
            host.wp_n = 1'b1;
        end
        host.desel();
    endtask
    task automatic wr_byte(input logic [15:0] a, input logic [7:0] dv);
        latch_set();
        host.sel();
        xb(OP_ARRAY_WRITE);
        xb(a[15:8]);
        xb(a[7:0]);
        xb(dv);
        host.desel();
        mem_exp[int'(a[13:0])] = dv;
    endtask
    task automatic rd_array(input logic [15:0] a, input int n, input int hold_at,
                            input logic idp);
        host.sel();
        xb(OP_ARRAY_READ);
        xb(a[15:8]);
        xb(a[7:0]);
        for (int i = 0; i < n; i++) begin
            xb(8'h00, i == 0 ? hold_at : 8);
            chk("array byte", exp_byte(a + 16'(i), idp), rx);
            chk("read drive", 8'h01, {7'h0, oe_any});
            if (i == 0 && hold_at < 8) chk("hold drive", 8'h00, {7'h0, oe_hold});
        end
        host.desel();
    endtask
    task automatic ignored(input logic [7:0] opc);
        host.sel();
        oe_acc = 1'b0;
        repeat (4) begin
            xb(opc);
            oe_acc = oe_acc | oe_any;
        end
        host.desel();
        chk("ignored drive", 8'h00, {7'h0, oe_acc});
    endtask
    initial begin
        repeat (8) @(posedge core_clk);
        #2 reset_n = 1'b1;
        chk("outputs at reset", 8'h00, {6'h0, so_oe, write_busy});
        rd_status();
        chk("status at reset", 8'h00, st);
        rd_array(16'h0100 + 16'($random(seed) & 16'h1FFF), 3, 3, 1'b0);
        d0 = 8'($random(seed));
        d1 = 8'($random(seed));
        wr_byte(16'h0000, d0);
        ignored(OP_ARRAY_READ);
        wait_ready();
        chk("latch after write", 8'h00, st);
        wr_byte(16'h3FFF, d1);
        wait_ready();
        host.set_mode(1'b1);
        rd_array(16'hFFFE, 4, 5, 1'b0);
        host.set_mode(1'b0);
        v = 8'h80 | (8'($random(seed)) & 8'h2C);
        wr_status(v, 1'b0);
        chk("busy after commit", 8'h01, {7'h0, write_busy});
        rd_status();
        chk("status while busy", 8'hFF, st);
        wait_ready();
        chk("status written", v & 8'hDC, st);
        host.wp_n = 1'b0;
        wr_status(8'h00, 1'b0);
        wait_ready();
        chk("refused status", (v & 8'hDC) | 8'h02, st);
        host.wp_n = 1'b1;
        wr_status(8'h00, 1'b1);
        wait_ready();
        chk("aborted status", (v & 8'hDC) | 8'h02, st);
        wr_status(8'h00, 1'b0);
        host.wp_n = 1'b0;
        wait_ready();
        chk("status completed", 8'h00, st);
        wr_status(8'h4C, 1'b0);
        wait_ready();
        chk("status gate off", 8'h4C, st);
        host.wp_n = 1'b1;
        rd_array(16'hFFFE, 2, 8, 1'b1);
        rd_status();
        chk("id select cleared", 8'h0C, st);
        for (int k = 0; k < 4; k++) begin
            op = 8'($random(seed));
            if (op < 8'h07) op = 8'hA5;
            ignored(op);
        end
        report_and_stop();
    end
endmodule
